// file: hw/viu_axil_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "viu_consts.vh"

module viu_axil_slave #(
	parameter ADDR_W = `VIU_ADDR_W,
	parameter DATA_W = `VIU_DATA_W
) (
	// clock and reset
	input  wire                  ref_clk_in,
	input  wire                  rst_b_in,
	// write address and data
	input  wire [ADDR_W-1:0]     s_axi_awaddr_in,
	input  wire                  s_axi_awvalid_in,
	output reg                   s_axi_awready_out,
	input  wire [DATA_W-1:0]     s_axi_wdata_in,
	input  wire [DATA_W/8-1:0]   s_axi_wstrb_in,
	input  wire                  s_axi_wvalid_in,
	output reg                   s_axi_wready_out,
	// write response
	output reg  [1:0]            s_axi_bresp_out,
	output reg                   s_axi_bvalid_out,
	input  wire                  s_axi_bready_in,
	// read address and data
	input  wire [ADDR_W-1:0]     s_axi_araddr_in,
	input  wire                  s_axi_arvalid_in,
	output reg                   s_axi_arready_out,
	output reg  [DATA_W-1:0]     s_axi_rdata_out,
	output reg  [1:0]            s_axi_rresp_out,
	output reg                   s_axi_rvalid_out,
	input  wire                  s_axi_rready_in,
	// register side
	output wire                  wr_en_out,
	output reg  [ADDR_W-1:0]     wr_addr_out,
	output reg  [DATA_W-1:0]     wr_data_out,
	output reg  [DATA_W/8-1:0]   wr_strb_out,
	input  wire                  wr_err_in,
	output wire                  rd_en_out,
	output wire [ADDR_W-1:0]     rd_addr_out,
	input  wire [DATA_W-1:0]     rd_data_in,
	input  wire                  rd_err_in
);

	reg aw_full_reg;
	reg w_full_reg;

	// write fires once both halves are held and no response is pending
	assign wr_en_out   = aw_full_reg & w_full_reg & ~s_axi_bvalid_out;
	assign rd_en_out   = s_axi_arvalid_in & s_axi_arready_out;
	assign rd_addr_out = s_axi_araddr_in;

	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			aw_full_reg       <= 1'b0;
			w_full_reg        <= 1'b0;
			wr_addr_out       <= {ADDR_W{1'b0}};
			wr_data_out       <= {DATA_W{1'b0}};
			wr_strb_out       <= {(DATA_W/8){1'b0}};
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `VIU_RESP_OKAY;
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= {DATA_W{1'b0}};
			s_axi_rresp_out   <= `VIU_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_full_reg       <= 1'b1;
				wr_addr_out       <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end else if (!aw_full_reg && !s_axi_bvalid_out) begin
				s_axi_awready_out <= 1'b1;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_full_reg       <= 1'b1;
				wr_data_out      <= s_axi_wdata_in;
				wr_strb_out      <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end else if (!w_full_reg && !s_axi_bvalid_out) begin
				s_axi_wready_out <= 1'b1;
			end
			if (wr_en_out) begin
				aw_full_reg      <= 1'b0;
				w_full_reg       <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= wr_err_in ? `VIU_RESP_SLVERR : `VIU_RESP_OKAY;
			end else if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
			// one read in flight: arready drops until the data is taken
			if (rd_en_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out  <= 1'b1;
				s_axi_rdata_out   <= rd_err_in ? {DATA_W{1'b0}} : rd_data_in;
				s_axi_rresp_out   <= rd_err_in ? `VIU_RESP_SLVERR : `VIU_RESP_OKAY;
			end else if (s_axi_rvalid_out) begin
				if (s_axi_rready_in) begin
					s_axi_rvalid_out <= 1'b0;
				end
			end else begin
				s_axi_arready_out <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// file: hw/viu_consts.vh
`ifndef VIU_CONSTS_VH
`define VIU_CONSTS_VH

// source count and bus geometry
`define VIU_NSRC        32
`define VIU_DATA_W      32
`define VIU_ADDR_W      32
`define VIU_LANES       4
`define VIU_LANE_W      8

// register byte addresses
`define VIU_ADDR_IRQ_STAT  32'hfffff000
`define VIU_ADDR_FIQ_STAT  32'hfffff004
`define VIU_ADDR_RAW_STAT  32'hfffff008
`define VIU_ADDR_CLASS     32'hfffff00c
`define VIU_ADDR_EN_SET    32'hfffff010
`define VIU_ADDR_EN_CLR    32'hfffff014
`define VIU_ADDR_SW_SET    32'hfffff018
`define VIU_ADDR_SW_CLR    32'hfffff01c
`define VIU_ADDR_EVT_STAT  32'hfffff040
`define VIU_ADDR_EVT_MASK  32'hfffff044

// reset values
`define VIU_RST_WORD    32'h00000000
`define VIU_RST_BIT     1'b0

// bus responses
`define VIU_RESP_OKAY   2'b00
`define VIU_RESP_SLVERR 2'b10

`endif

// file: hw/viu_event_flags.v
`timescale 1ns/1ps
`default_nettype none
`include "viu_consts.vh"

module viu_event_flags #(
	parameter N = `VIU_NSRC
) (
	// clock and reset
	input  wire         ref_clk_in,
	input  wire         rst_b_in,
	// events and software access
	input  wire [N-1:0] event_in,
	input  wire [N-1:0] clear_in,
	input  wire         mask_we_in,
	input  wire [N-1:0] mask_keep_in,
	input  wire [N-1:0] mask_data_in,
	// state
	output reg  [N-1:0] status_out,
	output reg  [N-1:0] mask_out,
	output reg          irq_out
);

	wire [N-1:0] status_next;
	wire [N-1:0] mask_next;

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_bit
			// an event in the clearing cycle survives the clear
			assign status_next[g] = event_in[g] | (status_out[g] & ~clear_in[g]);
			assign mask_next[g]   = (mask_we_in && !mask_keep_in[g]) ?
			                        mask_data_in[g] : mask_out[g];
		end
	endgenerate

	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status_out <= {N{`VIU_RST_BIT}};
			mask_out   <= {N{`VIU_RST_BIT}};
			irq_out    <= `VIU_RST_BIT;
		end else begin
			status_out <= status_next;
			mask_out   <= mask_next;
			irq_out    <= |(status_next & mask_next);
		end
	end

endmodule
`default_nettype wire

// file: hw/viu_front_end.v
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "viu_consts.vh"

//Behaviour
//- hardware request ORed with software force
//- force-set writes ones set, zeros ignored
//- force-clear writes ones clear, zeros ignored
//- raw status shows combined request regardless
//- enable read shows permitted sources
//- enable-set writes ones set, zeros ignored
//- enable-clear writes ones clear, zeros ignored
//- class bit zero IRQ, one FIQ
//- IRQ status is raw, enabled, not fast
//- thirty-two sources, bit n means source n
//- FIQ status is raw, enabled, fast
module viu_front_end #(
	parameter N      = `VIU_NSRC,
	parameter ADDR_W = `VIU_ADDR_W,
	parameter DATA_W = `VIU_DATA_W
) (
	// clock and reset
	input  wire                  ref_clk_in,
	input  wire                  rst_b_in,
	// peripheral request lines
	input  wire [N-1:0]          hw_req_in,
	// to the processor core
	output reg                   irq_req_out,
	output reg                   fiq_req_out,
	output reg  [N-1:0]          irq_status_out,
	output reg  [N-1:0]          fiq_status_out,
	// request edge event interrupt
	output wire                  event_irq_out,
	// axi4-lite write address and data
	input  wire [ADDR_W-1:0]     s_axi_awaddr_in,
	input  wire                  s_axi_awvalid_in,
	output wire                  s_axi_awready_out,
	input  wire [DATA_W-1:0]     s_axi_wdata_in,
	input  wire [DATA_W/8-1:0]   s_axi_wstrb_in,
	input  wire                  s_axi_wvalid_in,
	output wire                  s_axi_wready_out,
	// axi4-lite write response
	output wire [1:0]            s_axi_bresp_out,
	output wire                  s_axi_bvalid_out,
	input  wire                  s_axi_bready_in,
	// axi4-lite read
	input  wire [ADDR_W-1:0]     s_axi_araddr_in,
	input  wire                  s_axi_arvalid_in,
	output wire                  s_axi_arready_out,
	output wire [DATA_W-1:0]     s_axi_rdata_out,
	output wire [1:0]            s_axi_rresp_out,
	output wire                  s_axi_rvalid_out,
	input  wire                  s_axi_rready_in
);

	// bus side
	wire                wr_en;
	wire [ADDR_W-1:0]   wr_addr;
	wire [DATA_W-1:0]   wr_data;
	wire [DATA_W/8-1:0] wr_strb;
	reg                 wr_err;
	wire                rd_en;
	wire [ADDR_W-1:0]   rd_addr;
	reg  [DATA_W-1:0]   rd_data;
	reg                 rd_err;

	// stored state
	reg  [N-1:0]        soft_force_reg;
	reg  [N-1:0]        soft_force_next;
	reg  [N-1:0]        enable_reg;
	reg  [N-1:0]        enable_next;
	reg  [N-1:0]        class_reg;
	reg  [N-1:0]        class_next;
	reg  [N-1:0]        raw_prev_reg;

	// derived vectors
	wire [DATA_W-1:0]   lane_mask;
	wire [N-1:0]        wr_ones;
	wire [N-1:0]        wr_keep;
	wire [N-1:0]        raw_req;
	wire [N-1:0]        irq_vec;
	wire [N-1:0]        fiq_vec;
	wire [N-1:0]        req_event;
	wire [N-1:0]        evt_status;
	wire [N-1:0]        evt_mask;
	wire [N-1:0]        evt_clear;
	wire                evt_mask_we;

	viu_axil_slave #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W)
	) u_bus (
		.ref_clk_in        (ref_clk_in),
		.rst_b_in          (rst_b_in),
		.s_axi_awaddr_in   (s_axi_awaddr_in),
		.s_axi_awvalid_in  (s_axi_awvalid_in),
		.s_axi_awready_out (s_axi_awready_out),
		.s_axi_wdata_in    (s_axi_wdata_in),
		.s_axi_wstrb_in    (s_axi_wstrb_in),
		.s_axi_wvalid_in   (s_axi_wvalid_in),
		.s_axi_wready_out  (s_axi_wready_out),
		.s_axi_bresp_out   (s_axi_bresp_out),
		.s_axi_bvalid_out  (s_axi_bvalid_out),
		.s_axi_bready_in   (s_axi_bready_in),
		.s_axi_araddr_in   (s_axi_araddr_in),
		.s_axi_arvalid_in  (s_axi_arvalid_in),
		.s_axi_arready_out (s_axi_arready_out),
		.s_axi_rdata_out   (s_axi_rdata_out),
		.s_axi_rresp_out   (s_axi_rresp_out),
		.s_axi_rvalid_out  (s_axi_rvalid_out),
		.s_axi_rready_in   (s_axi_rready_in),
		.wr_en_out         (wr_en),
		.wr_addr_out       (wr_addr),
		.wr_data_out       (wr_data),
		.wr_strb_out       (wr_strb),
		.wr_err_in         (wr_err),
		.rd_en_out         (rd_en),
		.rd_addr_out       (rd_addr),
		.rd_data_in        (rd_data),
		.rd_err_in         (rd_err)
	);

	// byte strobes: lanes not strobed count as zeros, so set/clear ports ignore them
	genvar g;
	generate
		for (g = 0; g < `VIU_LANES; g = g + 1) begin : g_lane
			assign lane_mask[g*`VIU_LANE_W +: `VIU_LANE_W] = {`VIU_LANE_W{wr_strb[g]}};
		end
	endgenerate

	assign wr_ones = wr_data[N-1:0] & lane_mask[N-1:0];
	assign wr_keep = ~lane_mask[N-1:0];

	// combining stage, per bit position n
	assign raw_req   = hw_req_in | soft_force_reg;
	assign irq_vec   = raw_req & enable_reg & ~class_reg;
	assign fiq_vec   = raw_req & enable_reg & class_reg;
	assign req_event = raw_req & ~raw_prev_reg;

	// event flags live at their own word pair
	assign evt_mask_we = wr_en && (wr_addr == `VIU_ADDR_EVT_MASK);
	assign evt_clear   = (wr_en && (wr_addr == `VIU_ADDR_EVT_STAT)) ? wr_ones : {N{1'b0}};

	viu_event_flags #(
		.N (N)
	) u_events (
		.ref_clk_in   (ref_clk_in),
		.rst_b_in     (rst_b_in),
		.event_in     (req_event),
		.clear_in     (evt_clear),
		.mask_we_in   (evt_mask_we),
		.mask_keep_in (wr_keep),
		.mask_data_in (wr_data[N-1:0]),
		.status_out   (evt_status),
		.mask_out     (evt_mask),
		.irq_out      (event_irq_out)
	);

	// write side: only one address per write, so set and clear never collide
	always @* begin
		soft_force_next = soft_force_reg;
		enable_next     = enable_reg;
		class_next      = class_reg;
		wr_err          = 1'b0;
		if (wr_en) begin
			case (wr_addr)
				`VIU_ADDR_SW_SET: begin
					soft_force_next = soft_force_reg | wr_ones;
				end
				`VIU_ADDR_SW_CLR: begin
					soft_force_next = soft_force_reg & ~wr_ones;
				end
				`VIU_ADDR_EN_SET: begin
					enable_next = enable_reg | wr_ones;
				end
				`VIU_ADDR_EN_CLR: begin
					enable_next = enable_reg & ~wr_ones;
				end
				`VIU_ADDR_CLASS: begin
					class_next = (class_reg & wr_keep) | wr_ones;
				end
				// status words and the event pair accept a write here; only the event pair acts on it, in u_events
				`VIU_ADDR_IRQ_STAT,
				`VIU_ADDR_FIQ_STAT,
				`VIU_ADDR_RAW_STAT,
				`VIU_ADDR_EVT_STAT,
				`VIU_ADDR_EVT_MASK: begin
					wr_err = 1'b0;
				end
				default: begin
					wr_err = 1'b1;
				end
			endcase
		end
	end

	// read side: status words show the live vectors, not the one-cycle-late outputs
	always @* begin
		rd_data = `VIU_RST_WORD;
		rd_err  = 1'b0;
		if (rd_en) begin
			case (rd_addr)
				`VIU_ADDR_IRQ_STAT: begin
					rd_data[N-1:0] = irq_vec;
				end
				`VIU_ADDR_FIQ_STAT: begin
					rd_data[N-1:0] = fiq_vec;
				end
				`VIU_ADDR_RAW_STAT: begin
					rd_data[N-1:0] = raw_req;
				end
				`VIU_ADDR_CLASS: begin
					rd_data[N-1:0] = class_reg;
				end
				`VIU_ADDR_EN_SET: begin
					rd_data[N-1:0] = enable_reg;
				end
				`VIU_ADDR_SW_SET: begin
					rd_data[N-1:0] = soft_force_reg;
				end
				`VIU_ADDR_EN_CLR,
				`VIU_ADDR_SW_CLR: begin
					rd_data = `VIU_RST_WORD;
				end
				`VIU_ADDR_EVT_STAT: begin
					rd_data[N-1:0] = evt_status;
				end
				`VIU_ADDR_EVT_MASK: begin
					rd_data[N-1:0] = evt_mask;
				end
				default: begin
					rd_err = 1'b1;
				end
			endcase
		end
	end

	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			soft_force_reg <= `VIU_RST_WORD;
			enable_reg     <= `VIU_RST_WORD;
			class_reg      <= `VIU_RST_WORD;
			raw_prev_reg   <= `VIU_RST_WORD;
			irq_status_out <= `VIU_RST_WORD;
			fiq_status_out <= `VIU_RST_WORD;
			irq_req_out    <= `VIU_RST_BIT;
			fiq_req_out    <= `VIU_RST_BIT;
		end else begin
			soft_force_reg <= soft_force_next;
			enable_reg     <= enable_next;
			class_reg      <= class_next;
			raw_prev_reg   <= raw_req;
			// registered outputs add one cycle of latency to the core inputs
			irq_status_out <= irq_vec;
			fiq_status_out <= fiq_vec;
			irq_req_out    <= |irq_vec;
			fiq_req_out    <= |fiq_vec;
		end
	end

endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "viu_consts.vh"

module testbench;
	logic        clk = 1'b0, rst_b = 1'b0;
	logic [31:0] cmd = 32'h0, awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic [3:0]  strb = 4'hf;
	wire  [31:0] hw, rdata, ist, fst;
	wire         awr, wr, bv, arr, rv, irq, fiq, evi;
	wire  [1:0]  bresp, rresp;
	logic [1:0]  eb[$];
	logic [33:0] er[$];
	int          miscompares = 0, checks = 0, cyc = 0;

	always #12.5 clk = ~clk;

	viu_periph_model i_viu_periph_model (.ref_clk_in(clk), .rst_b_in(rst_b),
		.req_cmd_in(cmd), .hw_req_out(hw));
	viu_front_end i_viu_front_end (.ref_clk_in(clk), .rst_b_in(rst_b), .hw_req_in(hw),
		.irq_req_out(irq), .fiq_req_out(fiq), .irq_status_out(ist), .fiq_status_out(fst),
		.event_irq_out(evi), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv),
		.s_axi_awready_out(awr), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(strb),
		.s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bv), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rready));

	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(string n, logic [33:0] e, logic [33:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask

	// responses are judged here, in order, against the notes of the driver
	always @(posedge clk) begin
		if (bv && bready)
			chk("bresp", eb.pop_front(), bresp);
		if (rv && rready)
			chk("read", er.pop_front(), {rresp, rdata});
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic step(int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic axw(logic [31:0] a, d, logic [1:0] r = `VIU_RESP_OKAY);
		eb.push_back(r);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while (!(bv && bready));
		// bready stays up between writes so that no call lowers and raises it in one step
	endtask

	task automatic axr(logic [31:0] a, e, logic [1:0] r = `VIU_RESP_OKAY);
		er.push_back({r, e});
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
		end while (!(rv && rready));
	endtask

	initial begin
		logic [31:0] h, s1, s2, c, e1, e2, ec, k, sw, en, ir, fr;
		void'($urandom(35014));
		step(10);
		rst_b <= 1'b1;
		step(1);
		axr(`VIU_ADDR_CLASS, `VIU_RST_WORD);
		axr(`VIU_ADDR_EN_SET, `VIU_RST_WORD);
		axr(`VIU_ADDR_SW_SET, `VIU_RST_WORD);
		axr(`VIU_ADDR_IRQ_STAT, `VIU_RST_WORD);
		axr(`VIU_ADDR_EN_CLR, `VIU_RST_WORD);
		axr(32'hfffff030, 32'h0, `VIU_RESP_SLVERR);
		axw(32'hfffff030, 32'h1, `VIU_RESP_SLVERR);
		$display("test reset done");
		h = $urandom;
		s1 = $urandom;
		s2 = $urandom;
		c = $urandom;
		cmd <= h;
		axw(`VIU_ADDR_SW_SET, s1);
		axw(`VIU_ADDR_SW_SET, s2);
		sw = s1 | s2;
		axr(`VIU_ADDR_SW_SET, sw);
		axr(`VIU_ADDR_RAW_STAT, h | sw);
		axw(`VIU_ADDR_SW_CLR, c);
		sw = sw & ~c;
		axr(`VIU_ADDR_SW_SET, sw);
		axr(`VIU_ADDR_RAW_STAT, h | sw);
		$display("test force done");
		e1 = $urandom;
		e2 = $urandom;
		ec = $urandom;
		k = $urandom;
		axw(`VIU_ADDR_EN_SET, e1);
		axw(`VIU_ADDR_EN_SET, e2);
		axw(`VIU_ADDR_EN_CLR, ec);
		en = (e1 | e2) & ~ec;
		axr(`VIU_ADDR_EN_SET, en);
		axw(`VIU_ADDR_CLASS, k);
		axr(`VIU_ADDR_CLASS, k);
		// only the low lane is strobed: the upper lanes of the class word must be kept
		strb <= 4'h1;
		axw(`VIU_ADDR_CLASS, ~k);
		axr(`VIU_ADDR_CLASS, {k[31:8], ~k[7:0]});
		strb <= 4'hf;
		axw(`VIU_ADDR_CLASS, k);
		axr(`VIU_ADDR_CLASS, k);
		axw(`VIU_ADDR_IRQ_STAT, $urandom);
		ir = (h | sw) & en & ~k;
		fr = (h | sw) & en & k;
		axr(`VIU_ADDR_IRQ_STAT, ir);
		axr(`VIU_ADDR_FIQ_STAT, fr);
		chk("irq_status", ir, ist);
		chk("irq_req", |ir, irq);
		chk("fiq_req", |fr, fiq);
		$display("test classify done");
		axw(`VIU_ADDR_SW_CLR, 32'hffffffff);
		axw(`VIU_ADDR_EN_SET, 32'hffffffff);
		for (int n = 0; n < 32; n++) begin
			cmd <= 32'h1 << n;
			step(4);
			chk("irq_status", (32'h1 << n) & ~k, ist);
			chk("fiq_status", (32'h1 << n) & k, fst);
		end
		$display("test sources done");
		cmd <= 32'h0;
		step(4);
		axw(`VIU_ADDR_EVT_STAT, 32'hffffffff);
		axw(`VIU_ADDR_EVT_MASK, 32'h1);
		step(2);
		chk("event_irq", 1'b0, evi);
		cmd <= 32'h1;
		step(4);
		chk("event_irq", 1'b1, evi);
		axw(`VIU_ADDR_EVT_MASK, 32'h0);
		step(2);
		chk("event_irq", 1'b0, evi);
		axw(`VIU_ADDR_EVT_MASK, 32'h1);
		axr(`VIU_ADDR_EVT_STAT, 32'h1);
		chk("event_irq", 1'b1, evi);
		axw(`VIU_ADDR_EVT_STAT, 32'h1);
		step(2);
		chk("event_irq", 1'b0, evi);
		$display("test events done");
		stop_test();
	end
endmodule

`default_nettype wire

// file: verification/viu_front_end_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "viu_consts.vh"

module viu_front_end_asserts #(
	parameter N      = 32,
	parameter DATA_W = 32
) (
	// clock and reset
	input wire logic              ref_clk_in,
	input wire logic              rst_b_in,
	// core side
	input wire logic              irq_req_out,
	input wire logic              fiq_req_out,
	input wire logic [N-1:0]      irq_status_out,
	input wire logic [N-1:0]      fiq_status_out,
	// bus
	input wire logic              s_axi_awvalid_in,
	input wire logic              s_axi_awready_out,
	input wire logic              s_axi_wvalid_in,
	input wire logic              s_axi_wready_out,
	input wire logic              s_axi_bvalid_out,
	input wire logic              s_axi_bready_in,
	input wire logic [1:0]        s_axi_bresp_out,
	input wire logic              s_axi_arvalid_in,
	input wire logic              s_axi_arready_out,
	input wire logic              s_axi_rvalid_out,
	input wire logic              s_axi_rready_in,
	input wire logic [1:0]        s_axi_rresp_out,
	input wire logic [DATA_W-1:0] s_axi_rdata_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);

	a_irq_or: assert property (irq_req_out == |irq_status_out)
		else $error("irq request differs from status");
	a_fiq_or: assert property (fiq_req_out == |fiq_status_out)
		else $error("fiq request differs from status");
	a_class_excl: assert property ((irq_status_out & fiq_status_out) == '0)
		else $error("source in both classes");
	a_b_latency: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |-> ##2 s_axi_bvalid_out)
		else $error("write response late");
	a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	a_r_latency: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read response late");
	a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	a_r_err_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == `VIU_RESP_SLVERR
		|-> s_axi_rdata_out == '0)
		else $error("error read data not zero");

	c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_rd_err: cover property (s_axi_rvalid_out && s_axi_rresp_out == `VIU_RESP_SLVERR);
	c_fiq: cover property ($rose(fiq_req_out));
endmodule

bind viu_front_end viu_front_end_asserts #(.N(N), .DATA_W(DATA_W)) i_viu_front_end_asserts (
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
	.irq_req_out(irq_req_out), .fiq_req_out(fiq_req_out),
	.irq_status_out(irq_status_out), .fiq_status_out(fiq_status_out),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_bresp_out(s_axi_bresp_out), .s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rready_in(s_axi_rready_in), .s_axi_rresp_out(s_axi_rresp_out),
	.s_axi_rdata_out(s_axi_rdata_out));

`default_nettype wire

// file: verification/viu_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module viu_periph_model (
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_b_in,
	// command from the bench
	input  wire logic [31:0] req_cmd_in,
	// request lines to the block
	output var  logic [31:0] hw_req_out
);
	// lines follow the command one cycle late, like a synchronised peripheral flag
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			hw_req_out <= 32'h0;
		else
			hw_req_out <= req_cmd_in;
	end
endmodule

`default_nettype wire
